// *** src/spi_rate_pkg.sv ***
// Shared constants and types for the serial port select, status and rate block.
package spi_rate_pkg;
    localparam int unsigned DATA_W     = 8;
    localparam int unsigned FIFO_DEPTH = 8;
    localparam int unsigned ADDR_W     = 8;
    // Register offsets.
    localparam logic [7:0] ADDR_CTRL = 8'ha1;
    localparam logic [7:0] ADDR_DIV  = 8'ha2;
    localparam logic [7:0] ADDR_DATA = 8'ha3;
    // Control register field positions.
    localparam int unsigned CTRL_ENABLE_BIT   = 0;
    localparam int unsigned CTRL_TXEMPTY_BIT  = 1;
    localparam int unsigned CTRL_MODE_LSB     = 2;
    localparam int unsigned CTRL_MASTER_BIT   = 6;
    localparam int unsigned CTRL_BUSY_BIT     = 7;
    // Reset values.
    localparam logic [1:0] MODE_RESET    = 2'h1;
    localparam logic [7:0] DIV_RESET     = 8'h00;
    localparam logic       ENABLE_RESET  = 1'b0;
    localparam logic       MASTER_RESET  = 1'b0;
    localparam logic       TXEMPTY_RESET = 1'b1;
    // Select mode encodings.
    localparam logic [1:0] MODE_THREE_WIRE = 2'h0;
    localparam logic [1:0] MODE_FOUR_WIRE  = 2'h1;
    // Last bit index of a byte transfer.
    localparam logic [2:0] LAST_BIT = 3'h7;

    typedef enum logic [1:0] {
        IDLE,
        MASTER_RUN,
        SLAVE_RUN
    } phase_e;
endpackage

// *** src/spi_byte_fifo.sv ***
// Small first-in first-out buffer for transmit bytes.
`timescale 1ns/100ps
`default_nettype none
module spi_byte_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic                   core_clk,
    input  wire logic                   sys_rst,
    input  wire logic                   in_valid,
    output logic                        in_ready,
    input  wire logic [WIDTH-1:0]       in_data,
    output logic                        out_valid,
    input  wire logic                   out_ready,
    output logic [WIDTH-1:0]            out_data,
    output logic [$clog2(DEPTH):0]      level
);
    localparam int unsigned PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW:0]                 wr_ptr;
        logic [PW:0]                 rd_ptr;
    } fifo_s;

    fifo_s s;
    fifo_s next_s;

    // Pointers carry one extra wrap bit so full and empty never alias.
    assign level     = s.wr_ptr - s.rd_ptr;
    assign in_ready  = (level != (PW+1)'(DEPTH));
    assign out_valid = (level != '0);
    assign out_data  = s.mem[s.rd_ptr[PW-1:0]];

    always_comb begin
        next_s = s;
        if (in_valid && in_ready) begin
            next_s.mem[s.wr_ptr[PW-1:0]] = in_data;
            next_s.wr_ptr = s.wr_ptr + 1'b1;
        end
        if (out_valid && out_ready) begin
            next_s.rd_ptr = s.rd_ptr + 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule // spi_byte_fifo
`default_nettype wire

// *** src/spi_half_period.sv ***
// Half-period tick generator for the master serial clock.
`timescale 1ns/100ps
`default_nettype none
module spi_half_period (
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    input  wire logic       run,
    input  wire logic [7:0] divider,
    output logic            tick
);
    typedef struct packed {
        logic [7:0] count;
    } div_s;

    div_s s;
    div_s next_s;

    // One tick every divider+1 clocks gives a full period of 2*(divider+1).
    assign tick = run && (s.count == divider);

    always_comb begin
        next_s = s;
        if (!run || tick) begin
            next_s.count = 8'h00;
        end else begin
            next_s.count = s.count + 8'h01;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule // spi_half_period
`default_nettype wire

// *** src/spi_select_mode_and_sck_rate.sv ***
// Serial port core: select line modes, transmit buffer status and clock rate.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
module spi_select_mode_and_sck_rate (
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr_stb,
    input  wire logic       rd_stb,
    output logic      [7:0] rdata,
    input  wire logic       sck_in,
    output logic            sck_out,
    output logic            sck_oe,
    input  wire logic       mosi_in,
    output logic            mosi_out,
    output logic            mosi_oe,
    input  wire logic       miso_in,
    output logic            miso_out,
    output logic            miso_oe,
    input  wire logic       slave_select_line_in,
    output logic            slave_select_line_out,
    output logic            slave_select_line_oe,
    output logic            tx_buffer_empty
);
    typedef struct packed {
        spi_rate_pkg::phase_e phase;
        logic [7:0]           shifter;
        logic [2:0]           bits;
        logic                 rx_bit;
        logic [7:0]           rx_buffer;
        logic                 sck;
        logic                 sck_prev;
        logic                 enable;
        logic                 master;
        logic [1:0]           select_mode_field;
        logic [7:0]           spi_clock_divider;
        logic [7:0]           sck_rate_field;
        logic                 tx_empty;
        logic [7:0]           rdata;
        logic                 sck_oe;
        logic                 mosi_oe;
        logic                 miso_oe;
        logic                 ss_out;
        logic                 ss_oe;
    } core_s;

    core_s s;
    core_s next_s;

    logic       push;
    logic       push_ready;
    logic       pop;
    logic       buf_valid;
    logic [7:0] buf_data;
    logic [3:0] buf_level;
    logic       half_tick;
    logic       selected;
    logic       sck_rise;
    logic       sck_fall;

    assign push = wr_stb && (addr == spi_rate_pkg::ADDR_DATA);

    spi_byte_fifo #(
        .WIDTH (spi_rate_pkg::DATA_W),
        .DEPTH (spi_rate_pkg::FIFO_DEPTH)
    ) u_tx_buffer (
        .core_clk  (core_clk),
        .sys_rst   (sys_rst),
        .in_valid  (push),
        .in_ready  (push_ready),
        .in_data   (wdata),
        .out_valid (buf_valid),
        .out_ready (pop),
        .out_data  (buf_data),
        .level     (buf_level)
    );

    spi_half_period u_rate (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .run      (s.phase == spi_rate_pkg::MASTER_RUN),
        .divider  (s.sck_rate_field),
        .tick     (half_tick)
    );

    // Slave selection by mode; a single master never answers as slave.
    always_comb begin
        if (s.select_mode_field == spi_rate_pkg::MODE_THREE_WIRE) begin
            selected = 1'b1;
        end else if (s.select_mode_field == spi_rate_pkg::MODE_FOUR_WIRE) begin
            selected = !slave_select_line_in;
        end else begin
            selected = 1'b0;
        end
    end

    // Pins are sampled directly since they are synchronous to core_clk.
    assign sck_rise = sck_in && !s.sck_prev;
    assign sck_fall = !sck_in && s.sck_prev;

    always_comb begin
        next_s = s;
        pop = 1'b0;
        next_s.rdata = 8'h00;
        next_s.sck_prev = sck_in;

        if (wr_stb) begin
            case (addr)
                spi_rate_pkg::ADDR_CTRL: begin
                    next_s.enable = wdata[spi_rate_pkg::CTRL_ENABLE_BIT];
                    next_s.master = wdata[spi_rate_pkg::CTRL_MASTER_BIT];
                    next_s.select_mode_field =
                        wdata[spi_rate_pkg::CTRL_MODE_LSB +: 2];
                end
                spi_rate_pkg::ADDR_DIV: begin
                    next_s.spi_clock_divider = wdata;
                end
                default: begin
                end
            endcase
        end

        if (rd_stb) begin
            case (addr)
                spi_rate_pkg::ADDR_CTRL: begin
                    next_s.rdata[spi_rate_pkg::CTRL_ENABLE_BIT] = s.enable;
                    next_s.rdata[spi_rate_pkg::CTRL_TXEMPTY_BIT] = s.tx_empty;
                    next_s.rdata[spi_rate_pkg::CTRL_MODE_LSB +: 2] =
                        s.select_mode_field;
                    next_s.rdata[spi_rate_pkg::CTRL_MASTER_BIT] = s.master;
                    next_s.rdata[spi_rate_pkg::CTRL_BUSY_BIT] =
                        (s.phase != spi_rate_pkg::IDLE);
                end
                spi_rate_pkg::ADDR_DIV: begin
                    next_s.rdata = s.spi_clock_divider;
                end
                spi_rate_pkg::ADDR_DATA: begin
                    next_s.rdata = s.rx_buffer;
                end
                default: begin
                    next_s.rdata = 8'h00;
                end
            endcase
        end

        case (s.phase)
            spi_rate_pkg::IDLE: begin
                next_s.sck = 1'b0;
                next_s.bits = 3'h0;
                if (s.enable && s.master && buf_valid) begin
                    pop = 1'b1;
                    next_s.shifter = buf_data;
                    // Latching here keeps a mid-transfer divider write from
                    // stretching one half period; it applies next byte.
                    next_s.sck_rate_field = s.spi_clock_divider;
                    next_s.phase = spi_rate_pkg::MASTER_RUN;
                end else if (s.enable && !s.master && selected) begin
                    pop = buf_valid;
                    next_s.shifter = buf_valid ? buf_data : 8'h00;
                    next_s.phase = spi_rate_pkg::SLAVE_RUN;
                end
            end
            spi_rate_pkg::MASTER_RUN: begin
                if (!s.enable || !s.master) begin
                    next_s.sck = 1'b0;
                    next_s.phase = spi_rate_pkg::IDLE;
                end else if (half_tick && !s.sck) begin
                    next_s.sck = 1'b1;
                    next_s.rx_bit = miso_in;
                end else if (half_tick) begin
                    next_s.sck = 1'b0;
                    next_s.shifter = {s.shifter[6:0], s.rx_bit};
                    next_s.bits = s.bits + 3'h1;
                    if (s.bits == spi_rate_pkg::LAST_BIT) begin
                        next_s.rx_buffer = {s.shifter[6:0], s.rx_bit};
                        next_s.phase = spi_rate_pkg::IDLE;
                    end
                end
            end
            spi_rate_pkg::SLAVE_RUN: begin
                if (!s.enable || s.master || !selected) begin
                    next_s.phase = spi_rate_pkg::IDLE;
                end else if (sck_rise) begin
                    next_s.rx_bit = mosi_in;
                end else if (sck_fall) begin
                    next_s.shifter = {s.shifter[6:0], s.rx_bit};
                    next_s.bits = s.bits + 3'h1;
                    if (s.bits == spi_rate_pkg::LAST_BIT) begin
                        next_s.rx_buffer = {s.shifter[6:0], s.rx_bit};
                        next_s.phase = spi_rate_pkg::IDLE;
                    end
                end
            end
            default: begin
                next_s.phase = spi_rate_pkg::IDLE;
            end
        endcase

        // A write in the same cycle as the last pop leaves data buffered,
        // so the clear takes precedence only because the buffer is not empty.
        if (push && push_ready) begin
            next_s.tx_empty = 1'b0;
        end else if (pop && (buf_level == 4'h1)) begin
            next_s.tx_empty = 1'b1;
        end

        next_s.ss_oe = next_s.select_mode_field[1];
        next_s.ss_out = next_s.select_mode_field[0];
        next_s.sck_oe = next_s.enable && next_s.master;
        next_s.mosi_oe = next_s.enable && next_s.master;
        next_s.miso_oe = next_s.enable && !next_s.master && selected;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            s <= '0;
            s.phase <= spi_rate_pkg::IDLE;
            s.enable <= spi_rate_pkg::ENABLE_RESET;
            s.master <= spi_rate_pkg::MASTER_RESET;
            s.select_mode_field <= spi_rate_pkg::MODE_RESET;
            s.spi_clock_divider <= spi_rate_pkg::DIV_RESET;
            s.sck_rate_field <= spi_rate_pkg::DIV_RESET;
            s.tx_empty <= spi_rate_pkg::TXEMPTY_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign rdata                 = s.rdata;
    assign sck_out               = s.sck;
    assign sck_oe                = s.sck_oe;
    assign mosi_out              = s.shifter[7];
    assign mosi_oe               = s.mosi_oe;
    assign miso_out              = s.shifter[7];
    assign miso_oe               = s.miso_oe;
    assign slave_select_line_out = s.ss_out;
    assign slave_select_line_oe  = s.ss_oe;
    assign tx_buffer_empty       = s.tx_empty;
endmodule // spi_select_mode_and_sck_rate
`default_nettype wire

// *** verif/spi_rate_properties.sv ***
// Concurrent checks on the pins of the serial port core.
`timescale 1ns/100ps
`default_nettype none
module spi_rate_properties (
    input wire logic       core_clk,
    input wire logic       sys_rst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr_stb,
    input wire logic       rd_stb,
    input wire logic [7:0] rdata,
    input wire logic       sck_out,
    input wire logic       sck_oe,
    input wire logic       mosi_out,
    input wire logic       slave_select_line_out,
    input wire logic       slave_select_line_oe,
    input wire logic       tx_buffer_empty
);
    logic [1:0] mode;
    logic [7:0] div;
    logic [1:0] settle;
    logic [8:0] hi_len;
    // Shadows assume the divider is only rewritten between transfers.
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            mode   <= spi_rate_pkg::MODE_RESET;
            div    <= spi_rate_pkg::DIV_RESET;
            settle <= 2'h0;
        end else if (wr_stb && addr == spi_rate_pkg::ADDR_CTRL) begin
            mode   <= wdata[3:2];
            settle <= 2'h0;
        end else begin
            if (wr_stb && addr == spi_rate_pkg::ADDR_DIV) begin
                div <= wdata;
            end
            settle <= (settle == 2'h2) ? settle : settle + 2'h1;
        end
        hi_len <= sck_out ? hi_len + 9'h001 : 9'h000;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    sequence data_write;
        wr_stb && addr == spi_rate_pkg::ADDR_DATA;
    endsequence
    a_select_drive: assert property (settle == 2'h2 |-> slave_select_line_oe == mode[1])
        else $error("select enable differs from mode");
    a_select_level: assert property (settle == 2'h2 && mode[1] |-> slave_select_line_out == mode[0])
        else $error("select level differs from mode");
    a_write_clears: assert property (data_write |=> !tx_buffer_empty)
        else $error("empty flag not cleared by write");
    a_empty_cause: assert property ($rose(tx_buffer_empty) |-> !$past(wr_stb) || $past(addr) != spi_rate_pkg::ADDR_DATA)
        else $error("empty flag set in a write cycle");
    a_half_high: assert property ($fell(sck_out) |-> hi_len == {1'b0, div} + 9'h001)
        else $error("serial clock high time wrong");
    a_idle_low: assert property (!sck_oe |-> !sck_out)
        else $error("serial clock not idle low");
    a_read_stand: assert property (!$past(rd_stb) |-> rdata == 8'h00)
        else $error("read data outside its cycle");
    a_div_read: assert property (rd_stb && addr == spi_rate_pkg::ADDR_DIV |=> rdata == div)
        else $error("divider readback wrong");
    a_mosi_hold: assert property (sck_out && $past(sck_out) |-> $stable(mosi_out))
        else $error("data out moved while clock high");
endmodule // spi_rate_properties
bind spi_select_mode_and_sck_rate spi_rate_properties u_spi_rate_properties (.core_clk, .sys_rst,
    .addr, .wdata, .wr_stb, .rd_stb, .rdata, .sck_out, .sck_oe, .mosi_out,
    .slave_select_line_out, .slave_select_line_oe, .tx_buffer_empty);
`default_nettype wire

// *** verif/spi_far_slave.sv ***
// Behavioural serial slave that answers the master clock.
`timescale 1ns/100ps
`default_nettype none
module spi_far_slave #(
    parameter logic [7:0] REPLY = 8'h96
) (
    input  wire logic       sck,
    input  wire logic       active,
    input  wire logic       mosi,
    output logic            miso,
    output logic [7:0]      got
);
    logic [7:0] sh = 8'h00;
    logic [2:0] n  = 3'h0;
    initial got = 8'h00;
    // A released line shows the inverse of its last bit, so a stale copy never passes.
    assign miso = active ? sh[7] : ~sh[7];
    always @(posedge active) begin
        sh = REPLY;
        n  = 3'h0;
    end
    always @(posedge sck) begin
        got <= {got[6:0], mosi};
    end
    always @(negedge sck) begin
        n  <= n + 3'h1;
        sh <= (n == 3'h7) ? REPLY : {sh[6:0], 1'b0};
    end
endmodule // spi_far_slave
`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench for the serial port core.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    localparam logic [7:0] REPLY = 8'h96;
    logic       core_clk = 1'b0;
    logic       sys_rst  = 1'b1;
    logic [7:0] addr     = 8'h00;
    logic [7:0] wdata    = 8'h00;
    logic       wr_stb   = 1'b0;
    logic       rd_stb   = 1'b0;
    logic [7:0] rdata, got;
    logic       sck_out, sck_oe, mosi_out, miso_in, ss_out, ss_oe, empty;
    logic       mosi_oe, miso_oe;
    logic       ss_in    = 1'b1;
    logic [7:0] divs [4] = '{8'h00, 8'h01, 8'h04, 8'hff};
    int         bad_count = 0;
    int         samples_checked = 0;
    int         cycles = 0;
    int         t;
    spi_select_mode_and_sck_rate u_spi_select_mode_and_sck_rate (.core_clk, .sys_rst, .addr,
        .wdata, .wr_stb, .rd_stb, .rdata, .sck_in(1'b0), .sck_out, .sck_oe, .mosi_in(1'b0),
        .mosi_out, .mosi_oe, .miso_in, .miso_out(), .miso_oe, .slave_select_line_in(ss_in),
        .slave_select_line_out(ss_out), .slave_select_line_oe(ss_oe), .tx_buffer_empty(empty));
    spi_far_slave #(.REPLY(REPLY)) u_spi_far_slave (.sck(sck_out), .active(sck_oe),
        .mosi(mosi_out), .miso(miso_in), .got(got));
    always #50 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge core_clk);
        wr_stb <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
        @(posedge core_clk);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge core_clk);
        rd_stb <= 1'b0;
        #1;
        chk(name, {8'h00, exp}, {8'h00, rdata});
    endtask
    initial begin
        repeat (10) @(posedge core_clk);
        sys_rst <= 1'b0;
        tick(2);
        chk("empty", 16'h1, {15'h0, empty});
        chk("select oe", 16'h0, {15'h0, ss_oe});
        rd(spi_rate_pkg::ADDR_DIV, spi_rate_pkg::DIV_RESET, "divider");
        rd(spi_rate_pkg::ADDR_CTRL, 8'h06, "control");
        rd(8'h00, 8'h00, "unmapped");
        for (int m = 0; m < 4; m++) begin
            wr(spi_rate_pkg::ADDR_CTRL, 8'(m << 2));
            tick(2);
            chk("select oe", {15'h0, m[1]}, {15'h0, ss_oe});
            chk("select level", {15'h0, m[1] & m[0]}, {15'h0, ss_oe & ss_out});
        end
        // Slave answers only while selected in four-wire mode, always in three-wire mode.
        wr(spi_rate_pkg::ADDR_CTRL, 8'h05);
        tick(1);
        chk("miso oe", 16'h0, {15'h0, miso_oe});
        @(posedge core_clk);
        ss_in <= 1'b0;
        tick(2);
        chk("miso oe", 16'h1, {15'h0, miso_oe});
        @(posedge core_clk);
        ss_in <= 1'b1;
        wr(spi_rate_pkg::ADDR_CTRL, 8'h01);
        tick(1);
        chk("miso oe", 16'h1, {15'h0, miso_oe});
        wr(spi_rate_pkg::ADDR_CTRL, 8'h4d);
        tick(1);
        chk("mosi oe", 16'h1, {15'h0, mosi_oe});
        foreach (divs[i]) begin
            wr(spi_rate_pkg::ADDR_DIV, divs[i]);
            rd(spi_rate_pkg::ADDR_DIV, divs[i], "divider");
            wr(spi_rate_pkg::ADDR_DATA, 8'h3c ^ divs[i]);
            chk("empty", 16'h0, {15'h0, empty});
            t = 0;
            while (empty !== 1'b1 && t < 4) begin
                tick(1);
                t++;
            end
            chk("empty", 16'h1, {15'h0, empty});
            while (sck_out !== 1'b1) tick(1);
            t = 0;
            while (sck_out !== 1'b0) begin
                tick(1);
                t++;
            end
            while (sck_out !== 1'b1) begin
                tick(1);
                t++;
            end
            chk("sck period", 16'(2 * (divs[i] + 1)), 16'(t));
            tick(16 * (int'(divs[i]) + 1));
            rd(spi_rate_pkg::ADDR_DATA, REPLY, "receive");
            chk("wire byte", {8'h00, 8'h3c ^ divs[i]}, {8'h00, got});
        end
        // With the port disabled the bytes queue up, so the ninth meets a full buffer.
        wr(spi_rate_pkg::ADDR_DIV, 8'h00);
        wr(spi_rate_pkg::ADDR_CTRL, 8'h0c);
        for (int k = 0; k < 9; k++) wr(spi_rate_pkg::ADDR_DATA, 8'(k + 16));
        chk("empty", 16'h0, {15'h0, empty});
        wr(spi_rate_pkg::ADDR_CTRL, 8'h4d);
        tick(250);
        chk("wire byte", 16'h17, {8'h00, got});
        chk("empty", 16'h1, {15'h0, empty});
        rd(spi_rate_pkg::ADDR_DATA, REPLY, "receive");
        print_verdict();
    end
endmodule // testbench
`default_nettype wire
